/* att0_pkg.sv */
`default_nettype none
package att0_pkg;

  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_COUNT   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_COMPARE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ASYNC   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_MASK    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_FLAGS   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_SFC     = 8'h18;

  // async_clock_status fields; busy index doubles as bit position
  localparam int BUSY_CTL = 0;
  localparam int BUSY_CMP = 1;
  localparam int BUSY_CNT = 2;
  localparam int AS0_BIT  = 3;

  // timer_interrupt_mask and timer_interrupt_flags fields
  localparam int OCIE_BIT = 1;
  localparam int TOIE_BIT = 0;
  localparam int OCF_BIT  = 1;
  localparam int TOV_BIT  = 0;

  // special_function_control fields
  localparam int TSM_BIT    = 7;
  localparam int ACME_BIT   = 3;
  localparam int PUD_BIT    = 2;
  localparam int PRESCALER_RESET_ZERO_BIT   = 1;
  localparam int PRESCALER_RESET_SHARED_BIT = 0;

  // timer_control fields
  localparam int CTL_WGM0_BIT = 6;
  localparam int CTL_WGM1_BIT = 3;
  localparam int CTL_COM_LSB  = 4;
  localparam int CTL_CS_LSB   = 0;
  localparam logic [7:0] CTL_RW_MASK = 8'h7F;

  // reset values
  localparam logic [7:0] CTL_RST   = 8'h00;
  localparam logic [7:0] ASYNC_RST = 8'h00;
  localparam logic [7:0] SFC_RST   = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // timing counts
  localparam logic [1:0] XFER_EDGES       = 2'h2;
  localparam int         FLAG_SYNC_STAGES = 3;

  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  // prescaler
  localparam int         PRE_W        = 10;
  localparam logic [2:0] CS_STOP      = 3'h0;
  localparam logic [2:0] CS_DIRECT    = 3'h1;
  localparam logic [9:0] DIV8_MASK    = 10'h007;
  localparam logic [9:0] DIV32_MASK   = 10'h01F;
  localparam logic [9:0] DIV64_MASK   = 10'h03F;
  localparam logic [9:0] DIV128_MASK  = 10'h07F;
  localparam logic [9:0] DIV256_MASK  = 10'h0FF;
  localparam logic [9:0] DIV1024_MASK = 10'h3FF;

  typedef enum logic [1:0] {
    WGM_NORMAL,
    WGM_PHASE,
    WGM_CTC,
    WGM_FAST
  } att0_wgm_type;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } att0_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } att0_apb_rsp_type;

endpackage : att0_pkg
`default_nettype wire

/* att0_prescaler.sv */
`default_nettype none
module att0_prescaler #(
  parameter int PRE_W = att0_pkg::PRE_W
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  input  wire logic       src_tick_i,
  input  wire logic       clear_i,
  input  wire logic [2:0] sel_i,
  output logic            tick_o
);

  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } att0_pre_state_type;

  att0_pre_state_type st_reg;
  att0_pre_state_type st_next;

  function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h2:    div_mask = PRE_W'(att0_pkg::DIV8_MASK);
      3'h3:    div_mask = PRE_W'(att0_pkg::DIV32_MASK);
      3'h4:    div_mask = PRE_W'(att0_pkg::DIV64_MASK);
      3'h5:    div_mask = PRE_W'(att0_pkg::DIV128_MASK);
      3'h6:    div_mask = PRE_W'(att0_pkg::DIV256_MASK);
      default: div_mask = PRE_W'(att0_pkg::DIV1024_MASK);
    endcase
  endfunction : div_mask

  // a held reset also halts the timer, which is what sync hold relies on
  always_comb begin
    st_next = st_reg;
    tick_o  = 1'b0;
    if (clear_i) begin
      st_next.cnt = '0; // [RULE_19]
    end else if (src_tick_i) begin
      st_next.cnt = st_reg.cnt + PRE_W'(1);
      if (sel_i == att0_pkg::CS_DIRECT) begin
        tick_o = 1'b1;
      end else if (sel_i != att0_pkg::CS_STOP) begin
        tick_o = (st_reg.cnt & div_mask(sel_i)) == div_mask(sel_i); // [RULE_19]
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  clear_holds_a: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i || !ce_i)
    clear_i |-> !tick_o ##1 st_reg.cnt == '0) // [RULE_19]
    else $error("prescaler ticked or counted while held in reset");

endmodule : att0_prescaler
`default_nettype wire

/* att0_async_timer.sv */
// Summary of operation
// RULE_01 - async select picks oscillator pin, else core clock
// RULE_02 - async counter write sets busy until loaded
// RULE_03 - async compare write sets busy until loaded
// RULE_04 - async control write sets busy until loaded
// RULE_05 - software waits for busy clear before rewriting
// RULE_06 - counter reads live; compare/control read staging
// RULE_07 - staged write lands after two oscillator edges
// RULE_08 - software follows safe clock switch sequence
// RULE_09 - no compare match while write pending
// RULE_10 - wake logic rearms after one oscillator cycle
// RULE_11 - wake starts on next timer clock
// RULE_12 - counter view refreshed on each oscillator edge
// RULE_13 - software reads counter after a busy cycle
// RULE_14 - async flags take three cycles plus tick
// RULE_15 - compare pin changes on timer tick only
// RULE_16 - interrupt needs enable, flag and global enable
// RULE_17 - compare flag set on match, vector/W1C clears
// RULE_18 - overflow flag on wrap or bottom reversal
// RULE_19 - prescaler divides 1..1024 or stops, resettable
// RULE_20 - sync hold keeps prescaler resets asserted
// RULE_21 - prescaler reset self-clears, async waits edge
// RULE_22 - async select detaches oscillator port pins
// RULE_23 - sync mode writes direct, busy reads zero
`default_nettype none
module att0_async_timer (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       ce_i,
  input  wire att0_pkg::att0_apb_req_type apb_req_i,
  output att0_pkg::att0_apb_rsp_type      apb_rsp_o,
  input  wire logic                       osc_pin_in_i,
  input  wire logic                       sleep_i,
  input  wire logic                       global_irq_enable_i,
  input  wire logic                       compare_vec_ack_i,
  input  wire logic                       overflow_vec_ack_i,
  output logic                            compare_irq_o,
  output logic                            overflow_irq_o,
  output logic                            compare_out_o,
  output logic                            wake_o,
  output logic                            osc_pin_detach_o,
  output logic                            prescaler_reset_zero_o,
  output logic                            prescaler_reset_shared_o
);

  localparam int PIPE_W = att0_pkg::FLAG_SYNC_STAGES - 1;

  typedef struct packed {
    att0_pkg::att0_apb_rsp_type rsp;
    logic [7:0]       count;
    logic [7:0]       view;
    logic [7:0]       cmp;
    logic [7:0]       ctl;
    logic [7:0]       cnt_tmp;
    logic [7:0]       cmp_tmp;
    logic [7:0]       ctl_tmp;
    logic [2:0]       busy;
    logic [2:0][1:0]  edges;
    logic             as0;
    logic [1:0]       mask;
    logic             ocf;
    logic             tov;
    logic [PIPE_W-1:0] cpipe;
    logic [PIPE_W-1:0] opipe;
    logic             timer_sync_hold;
    logic             acme;
    logic             pud;
    logic             prescaler_reset_zero;
    logic             prescaler_reset_shared;
    logic             down;
    logic             oc_out;
    logic             osc_s1;
    logic             osc_s2;
    logic             osc_s3;
    logic             sleep_d;
    logic             rearm;
    logic             wake_arm;
    logic             wake;
    logic             cirq;
    logic             oirq;
  } att0_state_type;

  localparam att0_state_type ST_RST = '{
    ctl:     att0_pkg::CTL_RST,
    as0:     att0_pkg::ASYNC_RST[att0_pkg::AS0_BIT],
    mask:    att0_pkg::MASK_RST[1:0],
    ocf:     att0_pkg::FLAGS_RST[att0_pkg::OCF_BIT],
    tov:     att0_pkg::FLAGS_RST[att0_pkg::TOV_BIT],
    timer_sync_hold:     att0_pkg::SFC_RST[att0_pkg::TSM_BIT],
    default: '0
  };

  att0_state_type st_reg;
  att0_state_type st_next;

  logic                osc_rise;
  logic                src_tick;
  logic                tmr_tick;
  logic                access;
  logic                wr_en;
  logic                rd_cap;
  logic [att0_pkg::ADDR_W-1:0] addr;
  logic [7:0]          wdata;
  logic                wr_cnt;
  logic                wr_cmp;
  logic                wr_ctl;
  logic                wr_async;
  logic                wr_mask;
  logic                wr_flags;
  logic                wr_sfc;
  logic                match;
  att0_pkg::att0_wgm_type mode;
  logic                cmp_evt;
  logic                ovf_evt;
  logic                ocf_set;
  logic                tov_set;
  logic [7:0]          rd_byte;
  logic                mapped;
  logic [7:0]          cnt_n;

  // osc_s1 only feeds osc_s2; the edge is taken from the later stages
  assign osc_rise = st_reg.osc_s2 & ~st_reg.osc_s3;
  assign src_tick = st_reg.as0 ? osc_rise : 1'b1; // [RULE_01]

  assign access = apb_req_i.psel & apb_req_i.penable;
  assign wr_en  = access & apb_req_i.pwrite & st_reg.rsp.pready;
  assign rd_cap = access & ~st_reg.rsp.pready;
  assign addr   = apb_req_i.paddr;
  assign wdata  = apb_req_i.pwdata[7:0];

  assign wr_cnt   = wr_en & (addr == att0_pkg::OFF_COUNT);
  assign wr_cmp   = wr_en & (addr == att0_pkg::OFF_COMPARE);
  assign wr_ctl   = wr_en & (addr == att0_pkg::OFF_CONTROL);
  assign wr_async = wr_en & (addr == att0_pkg::OFF_ASYNC);
  assign wr_mask  = wr_en & (addr == att0_pkg::OFF_MASK);
  assign wr_flags = wr_en & (addr == att0_pkg::OFF_FLAGS);
  assign wr_sfc   = wr_en & (addr == att0_pkg::OFF_SFC);

  assign mode = att0_pkg::att0_wgm_type'({st_reg.ctl[att0_pkg::CTL_WGM1_BIT],
                                          st_reg.ctl[att0_pkg::CTL_WGM0_BIT]});

  // a pending counter or compare load would compare against stale data
  assign match = tmr_tick & (st_reg.count == st_reg.cmp)
               & ~st_reg.busy[att0_pkg::BUSY_CNT]
               & ~st_reg.busy[att0_pkg::BUSY_CMP]; // [RULE_09]

  att0_prescaler #(
    .PRE_W (att0_pkg::PRE_W)
  ) u_prescaler (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .src_tick_i (src_tick),
    .clear_i    (st_reg.prescaler_reset_zero),
    .sel_i      (st_reg.ctl[att0_pkg::CTL_CS_LSB +: 3]),
    .tick_o     (tmr_tick)
  );

  always_comb begin
    rd_byte = 8'h00;
    mapped  = 1'b1;
    case (addr)
      att0_pkg::OFF_COUNT:   rd_byte = st_reg.view; // [RULE_06] [RULE_12]
      att0_pkg::OFF_COMPARE: rd_byte = st_reg.cmp_tmp; // [RULE_06]
      att0_pkg::OFF_CONTROL: rd_byte = st_reg.ctl_tmp & att0_pkg::CTL_RW_MASK;
      att0_pkg::OFF_ASYNC:   rd_byte = {4'h0, st_reg.as0, st_reg.busy};
      att0_pkg::OFF_MASK:    rd_byte = {6'h00, st_reg.mask};
      att0_pkg::OFF_FLAGS:   rd_byte = {6'h00, st_reg.ocf, st_reg.tov};
      att0_pkg::OFF_SFC: begin
        rd_byte[att0_pkg::TSM_BIT]    = st_reg.timer_sync_hold;
        rd_byte[att0_pkg::ACME_BIT]   = st_reg.acme;
        rd_byte[att0_pkg::PUD_BIT]    = st_reg.pud;
        rd_byte[att0_pkg::PRESCALER_RESET_ZERO_BIT]   = st_reg.prescaler_reset_zero;
        rd_byte[att0_pkg::PRESCALER_RESET_SHARED_BIT] = st_reg.prescaler_reset_shared;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    cnt_n   = st_reg.count;
    ovf_evt = 1'b0;

    // one wait state: answer in the cycle after the access phase opens
    st_next.rsp.pready = rd_cap;
    if (rd_cap) begin
      st_next.rsp.prdata  = {24'h000000, rd_byte};
      st_next.rsp.pslverr = ~mapped;
    end

    st_next.osc_s1 = osc_pin_in_i;
    st_next.osc_s2 = st_reg.osc_s1;
    st_next.osc_s3 = st_reg.osc_s2;

    if (tmr_tick) begin
      case (mode)
        att0_pkg::WGM_PHASE: begin
          if (!st_reg.down) begin
            if (st_reg.count == att0_pkg::COUNT_MAX) begin
              st_next.down = 1'b1;
              cnt_n        = st_reg.count - 8'h01;
            end else begin
              cnt_n = st_reg.count + 8'h01;
            end
          end else if (st_reg.count == att0_pkg::COUNT_BOTTOM) begin
            st_next.down = 1'b0;
            ovf_evt      = 1'b1; // [RULE_18]
            cnt_n        = st_reg.count + 8'h01;
          end else begin
            cnt_n = st_reg.count - 8'h01;
          end
        end
        att0_pkg::WGM_CTC: begin
          ovf_evt = st_reg.count == att0_pkg::COUNT_MAX; // [RULE_18]
          cnt_n   = (st_reg.count == st_reg.cmp) ? att0_pkg::COUNT_BOTTOM
                                                  : st_reg.count + 8'h01;
        end
        default: begin
          st_next.down = 1'b0;
          ovf_evt      = st_reg.count == att0_pkg::COUNT_MAX; // [RULE_18]
          cnt_n        = st_reg.count + 8'h01;
        end
      endcase
    end
    st_next.count = cnt_n;
    cmp_evt       = match;

    // pin follows the timer tick directly, no core clock retiming
    if (match) begin
      case (st_reg.ctl[att0_pkg::CTL_COM_LSB +: 2])
        2'h1:    st_next.oc_out = ~st_reg.oc_out; // [RULE_15]
        2'h2:    st_next.oc_out = 1'b0;
        2'h3:    st_next.oc_out = 1'b1;
        default: st_next.oc_out = st_reg.oc_out;
      endcase
    end

    // each staging register runs its own edge count, so they never interfere
    for (int i = 0; i < 3; i++) begin
      if (st_reg.busy[i] && osc_rise) begin
        if (st_reg.edges[i] == att0_pkg::XFER_EDGES - 2'h1) begin
          st_next.busy[i] = 1'b0; // [RULE_02] [RULE_03] [RULE_04] [RULE_07]
          case (i)
            att0_pkg::BUSY_CNT: st_next.count = st_reg.cnt_tmp;
            att0_pkg::BUSY_CMP: st_next.cmp   = st_reg.cmp_tmp;
            default:            st_next.ctl   = st_reg.ctl_tmp;
          endcase
        end else begin
          st_next.edges[i] = st_reg.edges[i] + 2'h1;
        end
      end
    end

    // a rewrite while busy restarts the transfer; software must not do it
    if (wr_cnt) begin
      st_next.cnt_tmp = wdata;
      if (st_reg.as0) begin
        st_next.busy[att0_pkg::BUSY_CNT]  = 1'b1; // [RULE_02] [RULE_05]
        st_next.edges[att0_pkg::BUSY_CNT] = 2'h0;
      end else begin
        st_next.count = wdata; // [RULE_23]
      end
    end
    if (wr_cmp) begin
      st_next.cmp_tmp = wdata;
      if (st_reg.as0) begin
        st_next.busy[att0_pkg::BUSY_CMP]  = 1'b1; // [RULE_03]
        st_next.edges[att0_pkg::BUSY_CMP] = 2'h0;
      end else begin
        st_next.cmp = wdata; // [RULE_23]
      end
    end
    if (wr_ctl) begin
      st_next.ctl_tmp = wdata & att0_pkg::CTL_RW_MASK;
      if (st_reg.as0) begin
        st_next.busy[att0_pkg::BUSY_CTL]  = 1'b1; // [RULE_04]
        st_next.edges[att0_pkg::BUSY_CTL] = 2'h0;
      end else begin
        st_next.ctl = wdata & att0_pkg::CTL_RW_MASK; // [RULE_23]
      end
    end
    if (wr_async) begin
      st_next.as0 = wdata[att0_pkg::AS0_BIT]; // [RULE_01] [RULE_22]
    end
    if (!st_next.as0) begin
      st_next.busy = 3'h0; // [RULE_23]
    end

    // in sync mode every core cycle counts as a source edge
    if (src_tick) begin
      st_next.view = st_next.count; // [RULE_12]
    end

    // async events cross through two stages after the tick that made them
    st_next.cpipe = {st_reg.cpipe[PIPE_W-2:0], cmp_evt & st_reg.as0};
    st_next.opipe = {st_reg.opipe[PIPE_W-2:0], ovf_evt & st_reg.as0};
    ocf_set = st_reg.as0 ? st_reg.cpipe[PIPE_W-1] : cmp_evt; // [RULE_14]
    tov_set = st_reg.as0 ? st_reg.opipe[PIPE_W-1] : ovf_evt; // [RULE_14]

    // an event in the clearing cycle is kept
    st_next.ocf = (st_reg.ocf & ~(wr_flags & wdata[att0_pkg::OCF_BIT])
                  & ~compare_vec_ack_i) | ocf_set; // [RULE_17]
    st_next.tov = (st_reg.tov & ~(wr_flags & wdata[att0_pkg::TOV_BIT])
                  & ~overflow_vec_ack_i) | tov_set; // [RULE_18]

    if (wr_mask) begin
      st_next.mask = {wdata[att0_pkg::OCIE_BIT], wdata[att0_pkg::TOIE_BIT]};
    end

    if (wr_sfc) begin
      st_next.timer_sync_hold    = wdata[att0_pkg::TSM_BIT];
      st_next.acme   = wdata[att0_pkg::ACME_BIT];
      st_next.pud    = wdata[att0_pkg::PUD_BIT];
      st_next.prescaler_reset_zero   = wdata[att0_pkg::PRESCALER_RESET_ZERO_BIT];
      st_next.prescaler_reset_shared = wdata[att0_pkg::PRESCALER_RESET_SHARED_BIT];
      if (st_reg.timer_sync_hold && !wdata[att0_pkg::TSM_BIT]) begin
        st_next.prescaler_reset_zero   = 1'b0; // [RULE_20]
        st_next.prescaler_reset_shared = 1'b0;
      end
    end else if (!st_reg.timer_sync_hold) begin
      st_next.prescaler_reset_shared = 1'b0; // [RULE_21]
      if (!st_reg.as0 || osc_rise) begin
        st_next.prescaler_reset_zero = 1'b0; // [RULE_21]
      end
    end

    st_next.cirq = st_reg.mask[att0_pkg::OCIE_BIT] & st_reg.ocf
                 & global_irq_enable_i; // [RULE_16]
    st_next.oirq = st_reg.mask[att0_pkg::TOIE_BIT] & st_reg.tov
                 & global_irq_enable_i; // [RULE_16]

    // after wake-up the wake logic is blind until one oscillator edge
    st_next.sleep_d = sleep_i;
    if (st_reg.sleep_d && !sleep_i) begin
      st_next.rearm = 1'b1; // [RULE_10]
    end else if (osc_rise) begin
      st_next.rearm = 1'b0;
    end
    if (sleep_i && st_reg.as0 && !st_reg.rearm
        && ((cmp_evt && st_reg.mask[att0_pkg::OCIE_BIT])
         || (ovf_evt && st_reg.mask[att0_pkg::TOIE_BIT]))) begin
      st_next.wake_arm = 1'b1; // [RULE_10]
    end
    if (st_reg.wake_arm && osc_rise) begin
      st_next.wake     = 1'b1; // [RULE_11]
      st_next.wake_arm = 1'b0;
    end
    if (!sleep_i) begin
      st_next.wake     = 1'b0;
      st_next.wake_arm = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= ST_RST;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign apb_rsp_o                = st_reg.rsp;
  assign compare_irq_o            = st_reg.cirq;
  assign overflow_irq_o           = st_reg.oirq;
  assign compare_out_o            = st_reg.oc_out;
  assign wake_o                   = st_reg.wake;
  assign osc_pin_detach_o         = st_reg.as0; // [RULE_22]
  assign prescaler_reset_zero_o   = st_reg.prescaler_reset_zero;
  assign prescaler_reset_shared_o = st_reg.prescaler_reset_shared;

  busy_on_write_a: assert property (@(posedge core_clk_i) // [RULE_03]
    disable iff (!rst_n_i || !ce_i)
    wr_cmp && st_reg.as0 && !wr_async |=> st_reg.busy[att0_pkg::BUSY_CMP])
    else $error("compare write did not raise its busy flag");

  sync_busy_zero_a: assert property (@(posedge core_clk_i) // [RULE_23]
    disable iff (!rst_n_i || !ce_i)
    !st_reg.as0 |-> st_reg.busy == 3'h0)
    else $error("busy flag seen in synchronous mode");

  xfer_second_edge_a: assert property (@(posedge core_clk_i) // [RULE_07]
    disable iff (!rst_n_i || !ce_i)
    st_reg.busy[att0_pkg::BUSY_CMP] && osc_rise && !wr_cmp && !wr_async
    && st_reg.edges[att0_pkg::BUSY_CMP] == 2'h1
    |=> st_reg.cmp == $past(st_reg.cmp_tmp)
        && !st_reg.busy[att0_pkg::BUSY_CMP])
    else $error("staged compare not loaded on second edge");

  match_blocked_a: assert property (@(posedge core_clk_i) // [RULE_09]
    disable iff (!rst_n_i || !ce_i)
    st_reg.busy[att0_pkg::BUSY_CNT] || st_reg.busy[att0_pkg::BUSY_CMP]
    |=> $stable(st_reg.oc_out) && !(st_reg.cpipe[0]))
    else $error("compare matched while a load was pending");

  flag_sync_delay_a: assert property (@(posedge core_clk_i) // [RULE_14]
    disable iff (!rst_n_i || !ce_i)
    cmp_evt && st_reg.as0 ##1 st_reg.as0 |-> !st_reg.ocf || $past(st_reg.ocf)
      ##2 st_reg.ocf)
    else $error("async compare flag not set three cycles after tick");

  irq_gate_a: assert property (@(posedge core_clk_i) // [RULE_16]
    disable iff (!rst_n_i || !ce_i)
    compare_irq_o |-> $past(st_reg.ocf && global_irq_enable_i
                            && st_reg.mask[att0_pkg::OCIE_BIT]))
    else $error("compare interrupt without flag and enables");

  w1c_clear_a: assert property (@(posedge core_clk_i) // [RULE_17]
    disable iff (!rst_n_i || !ce_i)
    wr_flags && wdata[att0_pkg::OCF_BIT] && !ocf_set |=> !st_reg.ocf)
    else $error("write one did not clear compare flag");

  sync_hold_a: assert property (@(posedge core_clk_i) // [RULE_20]
    disable iff (!rst_n_i || !ce_i)
    st_reg.timer_sync_hold && st_reg.prescaler_reset_zero && !wr_sfc [*2] |-> st_reg.prescaler_reset_zero && !tmr_tick)
    else $error("prescaler reset dropped during sync hold");

  psr_selfclear_a: assert property (@(posedge core_clk_i) // [RULE_21]
    disable iff (!rst_n_i || !ce_i)
    st_reg.prescaler_reset_zero && !st_reg.timer_sync_hold && !st_reg.as0 && !wr_sfc && !wr_async
    |=> !st_reg.prescaler_reset_zero)
    else $error("prescaler reset did not self-clear");

  async_load_c: cover property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    st_reg.busy[att0_pkg::BUSY_CNT] ##[1:200] !st_reg.busy[att0_pkg::BUSY_CNT]);

  compare_irq_c: cover property (@(posedge core_clk_i)
    disable iff (!rst_n_i) $rose(compare_irq_o));

  wake_c: cover property (@(posedge core_clk_i)
    disable iff (!rst_n_i) $rose(wake_o));

  phase_ovf_c: cover property (@(posedge core_clk_i)
    disable iff (!rst_n_i) ovf_evt && mode == att0_pkg::WGM_PHASE);

endmodule : att0_async_timer
`default_nettype wire

/* att0_osc_model.sv */
`default_nettype none
module att0_osc_model (
  input  wire logic run_i,
  output logic      osc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // crystal runs free while enabled; 200 ns period keeps core 40x faster
  initial begin
    osc_o = 1'b0;
    forever begin
      #100;
      osc_o = run_i ? ~osc_o : 1'b0;
    end
  end
endmodule : att0_osc_model
`default_nettype wire

/* att0_async_timer_tb.sv */
`default_nettype none
module att0_async_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       clk, rst_n, gie, osc, irq, det, prescaler_reset_zero, err;
  logic                       oirq, oc, wk, shr, slp, ack;
  att0_pkg::att0_apb_req_type req;
  att0_pkg::att0_apb_rsp_type rsp;
  logic [31:0]                rd;
  logic [7:0]                 offs [3];
  int                         n_fail, n_tests;

  att0_osc_model xtal (.run_i(1'b1), .osc_o(osc));
  att0_async_timer dut (.core_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
    .apb_req_i(req), .apb_rsp_o(rsp), .osc_pin_in_i(osc), .sleep_i(slp),
    .global_irq_enable_i(gie), .compare_vec_ack_i(ack),
    .overflow_vec_ack_i(1'b0), .compare_irq_o(irq), .overflow_irq_o(oirq),
    .compare_out_o(oc), .wake_o(wk), .osc_pin_detach_o(det),
    .prescaler_reset_zero_o(prescaler_reset_zero), .prescaler_reset_shared_o(shr));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask : chk1

  // one APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    // no timeout here; a wait ends when pready is seen, or at the watchdog if it never is
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // software must see busy low before touching the register again
  task wait_busy(input int b);
    for (int k = 0; k < 60; k++) begin
      apb(1'b0, att0_pkg::OFF_ASYNC, 32'h0);
      if (rd[b] === 1'b0) break;
    end
  endtask : wait_busy

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    n_fail = 0;
    n_tests = 0;
    req = '0;
    gie = 1'b0;
    slp = 1'b0;
    ack = 1'b0;
    rst_n = 1'b0;
    offs = '{att0_pkg::OFF_CONTROL, att0_pkg::OFF_COMPARE,
             att0_pkg::OFF_COUNT};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, att0_pkg::OFF_ASYNC, 32'h0);
    chk("status", {24'h0, att0_pkg::ASYNC_RST}, rd);
    apb(1'b0, att0_pkg::OFF_SFC, 32'h0);
    chk("sfc", {24'h0, att0_pkg::SFC_RST}, rd);
    apb(1'b1, att0_pkg::OFF_SFC, 32'h2);
    apb(1'b0, att0_pkg::OFF_SFC, 32'h0);
    chk("psr_clr", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk1("slverr", 1'b1, err);
    apb(1'b1, att0_pkg::OFF_COMPARE, 32'h10);
    apb(1'b0, att0_pkg::OFF_ASYNC, 32'h0);
    chk("sync_busy", 32'h0, rd);
    apb(1'b0, att0_pkg::OFF_COMPARE, 32'h0);
    chk("compare", 32'h10, rd);
    gie <= 1'b1;
    apb(1'b1, att0_pkg::OFF_MASK, 32'h3);
    apb(1'b1, att0_pkg::OFF_CONTROL, 32'h31);
    for (int k = 0; k < 600 && irq !== 1'b1; k++) @(posedge clk);
    chk1("cmp_irq", 1'b1, irq);
    chk1("oc_pin", 1'b1, oc);
    apb(1'b0, att0_pkg::OFF_FLAGS, 32'h0);
    chk1("ocf_set", 1'b1, rd[att0_pkg::OCF_BIT]);
    apb(1'b1, att0_pkg::OFF_FLAGS, 32'h2);
    apb(1'b0, att0_pkg::OFF_FLAGS, 32'h0);
    chk1("ocf_clr", 1'b0, rd[att0_pkg::OCF_BIT]);
    for (int k = 0; k < 600 && oirq !== 1'b1; k++) @(posedge clk);
    chk1("ovf_irq", 1'b1, oirq);
    // the match after the wrap is cleared by the vector acknowledge alone
    for (int k = 0; k < 600 && irq !== 1'b1; k++) @(posedge clk);
    chk1("cmp_irq2", 1'b1, irq);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    apb(1'b0, att0_pkg::OFF_FLAGS, 32'h0);
    chk1("ocf_ack", 1'b0, rd[att0_pkg::OCF_BIT]);
    gie <= 1'b0;
    apb(1'b1, att0_pkg::OFF_MASK, 32'h0);
    apb(1'b1, att0_pkg::OFF_CONTROL, 32'h0);
    apb(1'b1, att0_pkg::OFF_ASYNC, 32'h8);
    apb(1'b0, att0_pkg::OFF_ASYNC, 32'h0);
    chk("as0", 32'h8, rd);
    chk1("detach", 1'b1, det);
    for (int i = 2; i >= 0; i--) begin
      apb(1'b1, offs[i], 32'h33);
      apb(1'b0, att0_pkg::OFF_ASYNC, 32'h0);
      chk1("busy", 1'b1, rd[i]);
      wait_busy(i);
      chk1("busy_clr", 1'b0, rd[i]);
      if (i == 1) begin
        apb(1'b0, att0_pkg::OFF_COUNT, 32'h0);
        chk("cnt_view", 32'h33, rd);
      end
    end
    apb(1'b0, att0_pkg::OFF_CONTROL, 32'h0);
    chk("ctl_rd", 32'h33, rd);
    apb(1'b1, att0_pkg::OFF_FLAGS, 32'h3);
    apb(1'b1, att0_pkg::OFF_MASK, 32'h2);
    // back-to-back staging into two registers must not interfere
    apb(1'b1, att0_pkg::OFF_COMPARE, 32'h44);
    apb(1'b1, att0_pkg::OFF_CONTROL, 32'h0);
    wait_busy(1);
    wait_busy(0);
    apb(1'b0, att0_pkg::OFF_COMPARE, 32'h0);
    chk("cmp_keep", 32'h44, rd);
    // sleep while the counter climbs from 0x40 to the compare value 0x44
    apb(1'b1, att0_pkg::OFF_COUNT, 32'h40);
    wait_busy(att0_pkg::BUSY_CNT);
    apb(1'b1, att0_pkg::OFF_CONTROL, 32'h1);
    wait_busy(att0_pkg::BUSY_CTL);
    slp <= 1'b1;
    for (int k = 0; k < 600 && wk !== 1'b1; k++) @(posedge clk);
    chk1("wake", 1'b1, wk);
    slp <= 1'b0;
    apb(1'b0, att0_pkg::OFF_COUNT, 32'h0);
    chk1("cnt_adv", 1'b1, rd[7:0] > 8'h44);
    chk1("wake_end", 1'b0, wk);
    apb(1'b1, att0_pkg::OFF_SFC, 32'h83);
    repeat (100) @(posedge clk);
    apb(1'b0, att0_pkg::OFF_SFC, 32'h0);
    chk("sfc_hold", 32'h83, rd);
    chk1("prescaler_reset_zero_out", 1'b1, prescaler_reset_zero);
    chk1("psr_shr", 1'b1, shr);
    apb(1'b1, att0_pkg::OFF_SFC, 32'h0);
    apb(1'b0, att0_pkg::OFF_SFC, 32'h0);
    chk("sfc_rel", 32'h0, rd);
    give_verdict();
  end
endmodule : att0_async_timer_tb
`default_nettype wire
